// ---- logic/sync_serial_port.sv ----
// synchronous serial port: spi master/slave, i2c start/stop, apb registers
// Notes on behaviour
// - slave select acts only in slave mode with select control
// - select low in that mode: shifting enabled, serial out driven
// - select high: serial out released after the two-flop select synchroniser, even mid-byte
// - select high in that mode resets the bit counter to zero
// - clearing port enable also resets the bit counter to zero
// - serial out pin set as input: no transmit drive on it
// - master mode in sleep freezes the transfer, resumes on wake
// - slave shift register keeps shifting on external clock in sleep
// - byte received in sleep sets flag and, if enabled, wakes device
// - any reset disables the port and drops the transfer, no flag
// - polarity/edge pairs map to the four standard spi modes
// - sample-phase bit picks mid-bit or end-of-bit input sampling in master mode; slave ignores it
// - i2c mode detects start and stop for a firmware master
// - i2c 7-bit and 10-bit modes are only decoded; no address match, no bus timing
// - port active only while control bit 5 is set
// - mode field also selects the i2c variants
// - enabled i2c mode makes clock and data pins open-drain
// - mode codes: master div 4/16/64, timer/2, two slave codes
// - msb first; after eight bits flag set, buffer loaded and full bit set unless still full
`timescale 1ns/10ps

module sync_serial_port (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire ssp_pkg::apb_req_t apb_req,
    output ssp_pkg::apb_rsp_t apb_rsp,
    // pins; sck doubles as i2c clock, sdi as i2c data
    input wire ssp_pkg::pin_in_t pin_in,
    output ssp_pkg::pin_out_t pin_out,
    // timer tick for the timer-rate master and wake request
    input wire logic tmr_tick,
    output logic wake_req
);
    import ssp_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [1:0] cfg;
        logic bf;
        logic start_seen;
        logic stop_seen;
        logic [7:0] buffer;
        logic [7:0] shreg;
        logic [7:0] flags;
        logic [7:0] ien;
        logic [3:0] pin_dir;
        logic sleep;
        logic wake;
        logic [2:0] bit_cnt;
        logic [4:0] half_cnt;
        logic [4:0] div_cnt;
        logic mbusy;
        logic sck_lvl;
        logic sck_oe;
        logic serial_out_pin;
        logic sdo_oe;
        logic ss_s1;
        logic ss_s2;
        logic sck_s1;
        logic sck_s2;
        logic sck_s3;
        logic sda_s1;
        logic sda_s2;
        logic sda_s3;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic enabled;
    port_mode_t mode;
    logic is_master;
    logic is_slave;
    logic is_i2c;
    logic ss_high;
    logic cke;
    logic input_sample_phase;
    logic sample_ev;
    logic out_ev;
    logic tick;
    logic lead;
    logic [4:0] half;
    logic [4:0] half_reload;
    logic [9:0] idx;
    logic setup;
    logic access;
    logic sck_rise;
    logic sck_fall;
    logic busy;
    logic [7:0] shifted;

    assign apb_rsp.prdata = st_r.prdata;
    assign apb_rsp.pready = st_r.pready;
    assign apb_rsp.pslverr = st_r.pslverr;
    assign pin_out.sck_o = st_r.sck_lvl;
    assign pin_out.sck_oe = st_r.sck_oe;
    assign pin_out.sdo_o = st_r.serial_out_pin;
    assign pin_out.sdo_oe = st_r.sdo_oe;
    assign wake_req = st_r.wake;

    always_comb begin
        st_nxt = st_r;
        sample_ev = 1'b0;
        out_ev = 1'b0;
        tick = 1'b0;
        lead = 1'b0;
        shifted = st_r.shreg;
        half = st_r.half_cnt;

        // two-flop synchronisers; edges seen on the second and third stage
        st_nxt.ss_s1 = pin_in.ss_n_i;
        st_nxt.ss_s2 = st_r.ss_s1;
        st_nxt.sck_s1 = pin_in.sck_i;
        st_nxt.sck_s2 = st_r.sck_s1;
        st_nxt.sck_s3 = st_r.sck_s2;
        st_nxt.sda_s1 = pin_in.sdi_i;
        st_nxt.sda_s2 = st_r.sda_s1;
        st_nxt.sda_s3 = st_r.sda_s2;
        sck_rise = st_r.sck_s2 && !st_r.sck_s3;
        sck_fall = !st_r.sck_s2 && st_r.sck_s3;

        enabled = st_r.ctrl[CTL_EN];
        mode = port_mode_t'(st_r.ctrl[3:0]);
        cke = st_r.cfg[0];
        input_sample_phase = st_r.cfg[1];
        // reserved codes match none of these, so nothing runs
        is_master = enabled && (mode == MODE_MST_DIV4 ||
            mode == MODE_MST_DIV16 || mode == MODE_MST_DIV64 ||
            mode == MODE_MST_TMR);
        is_slave = enabled && (mode == MODE_SLV_SEL ||
            mode == MODE_SLV_NOSEL);
        is_i2c = enabled && (mode == MODE_I2C_7 || mode == MODE_I2C_10 ||
            mode == MODE_I2C_FWM || mode == MODE_I2C_7_SP ||
            mode == MODE_I2C_10_SP);
        ss_high = (mode == MODE_SLV_SEL) && st_r.ss_s2;
        busy = st_r.mbusy || (st_r.bit_cnt != 3'h0);

        case (mode)
            MODE_MST_DIV4: half_reload = HALF_DIV4 - 5'h01;
            MODE_MST_DIV16: half_reload = HALF_DIV16 - 5'h01;
            default: half_reload = 5'(HALF_DIV64 - 6'h01);
        endcase

        // apb: zero wait state, answer registered at the setup edge
        setup = apb_req.psel && !apb_req.penable;
        access = apb_req.psel && apb_req.penable && st_r.pready;
        idx = apb_req.paddr[11:2];
        st_nxt.pready = setup;
        if (setup) begin
            st_nxt.pslverr = 1'b0;
            st_nxt.prdata = 32'h0000_0000;
            case (idx)
                IDX_IRQ_FLAGS: st_nxt.prdata[7:0] = {1'b0, st_r.flags[6:0]};
                IDX_DATA_BUF: st_nxt.prdata[7:0] = st_r.buffer;
                IDX_CONTROL: st_nxt.prdata[7:0] = st_r.ctrl;
                IDX_IRQ_ENABLES: st_nxt.prdata[7:0] = {1'b0, st_r.ien[6:0]};
                IDX_STATUS: st_nxt.prdata[7:0] = {st_r.cfg, 1'b0,
                    st_r.stop_seen, st_r.start_seen, 2'b00, st_r.bf};
                IDX_PIN_DIR: st_nxt.prdata[3:0] = st_r.pin_dir;
                IDX_POWER: st_nxt.prdata[PWR_SLEEP] = st_r.sleep;
                default: st_nxt.pslverr = 1'b1;
            endcase
        end else if (access) begin
            st_nxt.pslverr = 1'b0;
        end

        // software writes and read side effects; hardware sets follow
        if (access && apb_req.pwrite) begin
            case (idx)
                IDX_IRQ_FLAGS: st_nxt.flags = {1'b0, apb_req.pwdata[6:0]};
                IDX_IRQ_ENABLES: st_nxt.ien = {1'b0, apb_req.pwdata[6:0]};
                IDX_CONTROL: st_nxt.ctrl = apb_req.pwdata[7:0];
                IDX_STATUS: st_nxt.cfg = apb_req.pwdata[7:6];
                IDX_PIN_DIR: st_nxt.pin_dir = apb_req.pwdata[3:0];
                IDX_POWER: st_nxt.sleep = apb_req.pwdata[PWR_SLEEP];
                IDX_DATA_BUF: begin
                    if (busy) begin
                        // write during a transfer is dropped
                        st_nxt.ctrl[CTL_WRITE_COLLISION_FLAG] = 1'b1;
                    end else begin
                        st_nxt.shreg = apb_req.pwdata[7:0];
                        st_nxt.serial_out_pin = apb_req.pwdata[7];
                        if (is_master) begin
                            st_nxt.mbusy = 1'b1;
                            st_nxt.half_cnt = 5'h00;
                            st_nxt.div_cnt = half_reload;
                        end
                    end
                end
                default: ;
            endcase
        end
        if (access && !apb_req.pwrite && idx == IDX_DATA_BUF) begin
            st_nxt.bf = 1'b0;
        end

        // master: half-bit ticks, sixteen sck toggles then a closing tick
        if (is_master && st_r.mbusy && !st_r.sleep) begin
            if (mode == MODE_MST_TMR) begin
                tick = tmr_tick;
            end else if (st_r.div_cnt == 5'h00) begin
                tick = 1'b1;
                st_nxt.div_cnt = half_reload;
            end else begin
                st_nxt.div_cnt = st_r.div_cnt - 5'h01;
            end
            if (tick) begin
                lead = !half[0];
                if (half != HALF_LAST) begin
                    st_nxt.sck_lvl = !st_r.sck_lvl;
                end
                // end-of-bit sampling moves capture to the next output edge
                if (input_sample_phase) begin
                    sample_ev = cke ? !lead : (lead && half != 5'h00);
                end else begin
                    sample_ev = cke ? (lead && half != HALF_LAST) : !lead;
                end
                out_ev = (half != HALF_LAST) && (cke ? !lead : lead);
                st_nxt.half_cnt = half + 5'h01;
                if (half == HALF_LAST) begin
                    st_nxt.mbusy = 1'b0;
                end
            end
        end else if (!st_r.mbusy) begin
            st_nxt.sck_lvl = st_r.ctrl[CTL_CKP];
        end

        // slave: sck edges drive shifting regardless of sleep
        if (is_slave && !ss_high) begin
            lead = st_r.ctrl[CTL_CKP] ? sck_fall : sck_rise;
            sample_ev = cke ? lead : (sck_rise || sck_fall) && !lead;
            out_ev = cke ? (sck_rise || sck_fall) && !lead : lead;
        end

        // msb-first shift, capture on sample edge, present on output edge
        if (sample_ev) begin
            shifted = {st_r.shreg[6:0], st_r.sda_s2};
            st_nxt.shreg = shifted;
            st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
            if (st_r.bit_cnt == BIT_LAST) begin
                if (st_r.bf) begin
                    // unread buffer is kept, new byte lost
                    st_nxt.ctrl[CTL_OVF] = 1'b1;
                end else begin
                    st_nxt.buffer = shifted;
                    st_nxt.bf = 1'b1;
                end
                st_nxt.flags[IRQ_PORT] = 1'b1;
            end
        end
        if (out_ev) begin
            st_nxt.serial_out_pin = shifted[7];
        end

        // port reset by select high or by disable
        if (!enabled || ss_high) begin
            st_nxt.bit_cnt = 3'h0;
            st_nxt.half_cnt = 5'h00;
            st_nxt.mbusy = 1'b0;
            st_nxt.sck_lvl = st_r.ctrl[CTL_CKP];
        end

        // 7-bit and 10-bit variants only decoded; no address match
        // i2c start: data falls with clock high; stop: data rises
        if (is_i2c && st_r.sck_s2 && st_r.sck_s3) begin
            if (!st_r.sda_s2 && st_r.sda_s3) begin
                st_nxt.start_seen = 1'b1;
                st_nxt.stop_seen = 1'b0;
            end
            if (st_r.sda_s2 && !st_r.sda_s3) begin
                st_nxt.stop_seen = 1'b1;
                st_nxt.start_seen = 1'b0;
            end
            if ((st_r.sda_s2 != st_r.sda_s3) && (mode == MODE_I2C_FWM ||
                mode == MODE_I2C_7_SP || mode == MODE_I2C_10_SP)) begin
                st_nxt.flags[IRQ_PORT] = 1'b1;
            end
        end

        // pin drivers; direction bit set as input wins over the port
        st_nxt.sck_oe = is_master && !st_r.pin_dir[DIR_SCK];
        st_nxt.sdo_oe = !st_r.pin_dir[DIR_SDO] &&
            (is_master || (is_slave && !ss_high));
        // above: input direction keeps sdo released
        if (is_i2c) begin
            // open-drain: level low, enable only while pulling low; this
            // subset never pulls, so both lines stay released
            st_nxt.sck_lvl = 1'b0;
            st_nxt.sck_oe = 1'b0;
            st_nxt.sdo_oe = 1'b0;
        end

        st_nxt.wake = st_r.sleep && st_nxt.flags[IRQ_PORT] &&
            st_r.ien[IRQ_PORT];
    end

    // async reset: port disabled, transfer dropped, registers cleared, pin directions set to input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.ctrl <= RST_BYTE;
            st_r.flags <= RST_BYTE;
            st_r.ien <= RST_BYTE;
            st_r.pin_dir <= RST_PIN_DIR;
            st_r.ss_s1 <= 1'b1;
            st_r.ss_s2 <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

// ---- logic/ssp_pkg.sv ----
// package: register map, field positions, mode codes and carriers of the port
package ssp_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_IRQ_FLAGS = 10'h00c;
    localparam logic [9:0] IDX_DATA_BUF = 10'h013;
    localparam logic [9:0] IDX_CONTROL = 10'h014;
    localparam logic [9:0] IDX_IRQ_ENABLES = 10'h08c;
    localparam logic [9:0] IDX_STATUS = 10'h094;
    localparam logic [9:0] IDX_PIN_DIR = 10'h0a0;
    localparam logic [9:0] IDX_POWER = 10'h0a1;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_PIN_DIR = 4'hf;

    // control register fields
    localparam int CTL_WRITE_COLLISION_FLAG = 7;
    localparam int CTL_OVF = 6;
    localparam int CTL_EN = 5;
    localparam int CTL_CKP = 4;

    // status register fields
    localparam int STA_SMP = 7;
    localparam int STA_CKE = 6;
    localparam int STA_STOP = 4;
    localparam int STA_START = 3;
    localparam int STA_BF = 0;

    // irq flag / enable position of the port
    localparam int IRQ_PORT = 3;

    // pin direction register fields, 1 = input
    localparam int DIR_SDO = 0;
    localparam int DIR_SCK = 1;
    localparam int DIR_SS = 2;
    localparam int DIR_SDA = 3;

    // power register field
    localparam int PWR_SLEEP = 0;

    // mode field codes
    typedef enum logic [3:0] {
        MODE_MST_DIV4 = 4'b0000,
        MODE_MST_DIV16 = 4'b0001,
        MODE_MST_DIV64 = 4'b0010,
        MODE_MST_TMR = 4'b0011,
        MODE_SLV_SEL = 4'b0100,
        MODE_SLV_NOSEL = 4'b0101,
        MODE_I2C_7 = 4'b0110,
        MODE_I2C_10 = 4'b0111,
        MODE_I2C_FWM = 4'b1011,
        MODE_I2C_7_SP = 4'b1110,
        MODE_I2C_10_SP = 4'b1111
    } port_mode_t;

    // half bit periods in system clocks for the divided master rates
    localparam logic [4:0] HALF_DIV4 = 5'h02;
    localparam logic [4:0] HALF_DIV16 = 5'h08;
    // 32 does not fit five bits; the reload cuts it back after subtracting
    localparam logic [5:0] HALF_DIV64 = 6'h20;
    localparam logic [4:0] HALF_LAST = 5'h10;
    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic sck_i;
        logic sdi_i;
        logic ss_n_i;
    } pin_in_t;

    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic sdo_o;
        logic sdo_oe;
    } pin_out_t;

endpackage

// ---- test/ssp_checker.sv ----
// checker: bus timing and pin drive of the serial port
`timescale 1ns/10ps
module ssp_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // register bus
    input wire ssp_pkg::apb_req_t apb_req,
    input wire ssp_pkg::apb_rsp_t apb_rsp,
    // pins and side signals
    input wire ssp_pkg::pin_in_t pin_in,
    input wire ssp_pkg::pin_out_t pin_out,
    input wire logic tmr_tick,
    input wire logic wake_req
);
    import ssp_pkg::*;
    logic [7:0] ctl_r, ie_r, wd;
    logic [9:0] idx;
    logic dir_r, wr, sel, quiet;
    assign idx = apb_req.paddr[11:2];
    assign wd = apb_req.pwdata[7:0];
    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite
        && apb_rsp.pready;
    assign sel = ctl_r[5] && ctl_r[3:0] == 4'h4 && !dir_r;
    // i2c and reserved codes both leave every pin undriven
    assign quiet = !ctl_r[5] || ctl_r[3] || ctl_r[3:1] == 3'b011;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_r <= 8'h00;
            ie_r <= 8'h00;
            dir_r <= 1'b1;
        end else if (wr) begin
            if (idx == IDX_CONTROL) ctl_r <= wd;
            if (idx == IDX_IRQ_ENABLES) ie_r <= wd;
            if (idx == IDX_PIN_DIR) dir_r <= wd[0];
        end
    end
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_setup: assert property (
        apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
        else $error("no ready after setup");
    a_ready_single: assert property (
        apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready held too long");
    a_err_ready: assert property (
        apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("error without ready");
    a_sel_drive: assert property (
        (sel && !pin_in.ss_n_i) [*5] |-> pin_out.sdo_oe)
        else $error("serial out not driven while selected");
    a_sel_release: assert property (
        sel && $rose(pin_in.ss_n_i) |-> ##[1:4] !pin_out.sdo_oe)
        else $error("serial out kept after deselect");
    a_off_quiet: assert property (
        quiet [*3] |-> !pin_out.sdo_oe && !pin_out.sck_oe)
        else $error("pin driven while port inactive");
    a_dir_input: assert property (
        dir_r [*2] |-> !pin_out.sdo_oe)
        else $error("serial out driven while set as input");
    a_wake_enable: assert property (
        wake_req |-> ie_r[3] || $past(ie_r[3]))
        else $error("wake request without enable");
    c_sel_rise: cover property (sel && $rose(pin_in.ss_n_i));
    c_wake: cover property (wake_req);
    c_err: cover property (apb_rsp.pslverr);
endmodule

// ---- test/spi_master_model.sv ----
// model of the external spi master and i2c bus driving the port pins
`timescale 1ns/10ps
module spi_master_model #(
    parameter int HALF = 8
) (
    // clock
    input wire logic pclk,
    // serial out from the port
    input wire logic sdo_o,
    input wire logic sdo_oe,
    // lines into the port
    output logic sck,
    output logic serial_in_pin,
    output logic ss_n
);
    initial begin
        sck = 1'b0;
        serial_in_pin = 1'b1;
        ss_n = 1'b1;
    end
    // n below 8 aborts mid-byte; hold keeps the select low afterwards
    task automatic xfer(input logic cpol, input logic cpha,
        input logic [7:0] tx, input int n, input logic hold,
        output logic [7:0] rx);
        int i;
        rx = 8'h00;
        sck <= cpol;
        ss_n <= 1'b0;
        if (!cpha) serial_in_pin <= tx[7];
        repeat (2 * HALF) @(posedge pclk);
        for (i = 7; i > 7 - n; i--) begin
            if (!cpha) rx[i] = sdo_oe ? sdo_o : 1'bz;
            else serial_in_pin <= tx[i];
            sck <= ~cpol;
            repeat (HALF) @(posedge pclk);
            if (cpha) rx[i] = sdo_oe ? sdo_o : 1'bz;
            else if (i > 0) serial_in_pin <= tx[i - 1];
            sck <= cpol;
            repeat (HALF) @(posedge pclk);
        end
        if (!hold) ss_n <= 1'b1;
        // released data line shows the inverse, never a stale level
        serial_in_pin <= ~serial_in_pin;
        @(posedge pclk);
    endtask
    task automatic i2c_cond(input logic start);
        sck <= 1'b1;
        serial_in_pin <= start;
        repeat (HALF) @(posedge pclk);
        serial_in_pin <= ~start;
        repeat (HALF) @(posedge pclk);
    endtask
endmodule

// ---- test/sync_serial_port_tb_top.sv ----
// testbench: registers, spi slave and master traffic, i2c conditions
`timescale 1ns/10ps
module sync_serial_port_tb_top;
    import ssp_pkg::*;
    localparam logic [11:0] A_FLG = {IDX_IRQ_FLAGS, 2'b00};
    localparam logic [11:0] A_BUF = {IDX_DATA_BUF, 2'b00};
    localparam logic [11:0] A_CTL = {IDX_CONTROL, 2'b00};
    localparam logic [11:0] A_IE = {IDX_IRQ_ENABLES, 2'b00};
    localparam logic [11:0] A_STA = {IDX_STATUS, 2'b00};
    localparam logic [11:0] A_DIR = {IDX_PIN_DIR, 2'b00};
    localparam logic [11:0] A_PWR = {IDX_POWER, 2'b00};
    logic pclk, presetn, tmr_tick, wake_req, sck, serial_in_pin, ss_n, sck_p, oe_p, e;
    apb_req_t apb_req;
    apb_rsp_t apb_rsp;
    pin_in_t pin_in;
    pin_out_t pin_out;
    logic [7:0] q;
    logic [1:0] m;
    int fail_count = 0;
    int checked = 0;
    int tg = 0;
    int t0, t1;
    assign pin_in = {sck, serial_in_pin, ss_n};
    sync_serial_port sync_serial_port_inst (.pclk(pclk),
        .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .pin_in(pin_in), .pin_out(pin_out), .tmr_tick(tmr_tick),
        .wake_req(wake_req));
    spi_master_model spi_master_model_inst (.pclk(pclk),
        .sdo_o(pin_out.sdo_o), .sdo_oe(pin_out.sdo_oe),
        .sck(sck), .serial_in_pin(serial_in_pin), .ss_n(ss_n));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        tmr_tick <= ~tmr_tick;
        sck_p <= pin_out.sck_o;
        oe_p <= pin_out.sck_oe;
        if (oe_p && pin_out.sck_oe && pin_out.sck_o !== sck_p) tg <= tg + 1;
    end
    task automatic chk(input string nm, input logic [7:0] s,
        input logic [7:0] x);
        checked++;
        if (s !== x) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [7:0] d, output logic [7:0] rq, output logic re);
        int n;
        apb_req <= '{1'b1, 1'b0, w, a, 32'(d)};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 16);
        if (n >= 16) fail_count++;
        rq = apb_rsp.prdata[7:0];
        re = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] rq;
        logic re;
        apb(1'b1, a, d, rq, re);
    endtask
    task automatic rc(input string nm, input logic [11:0] a,
        input logic [7:0] x);
        logic [7:0] rq;
        logic re;
        apb(1'b0, a, 8'h00, rq, re);
        chk(nm, rq, x);
    endtask
    task automatic rst_chk();
        rc("flags", A_FLG, 8'h00);
        rc("buffer", A_BUF, 8'h00);
        rc("control", A_CTL, 8'h00);
        rc("enables", A_IE, 8'h00);
        rc("status", A_STA, 8'h00);
        rc("pin dir", A_DIR, 8'h0f);
        apb(1'b0, 12'h004, 8'h00, q, e);
        chk("unmapped err", {7'h00, e}, 8'h01);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic sx(input logic [7:0] tx, input int n, input logic h);
        spi_master_model_inst.xfer(1'b0, 1'b0, tx, n, h, q);
    endtask
    initial begin
        presetn = 1'b0;
        apb_req = '0;
        tmr_tick = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rst_chk();
        wr(A_DIR, 8'h0e);
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            wr(A_STA, {1'b0, ~m[0], 6'h00});
            wr(A_CTL, {3'b001, m[1], 4'h4});
            wr(A_BUF, 8'hc3 ^ 8'(i));
            spi_master_model_inst.xfer(m[1], m[0], 8'h96 + 8'(i), 8, 1'b0, q);
            chk("slave out", q, 8'hc3 ^ 8'(i));
            rc("status full", A_STA, {1'b0, ~m[0], 6'h01});
            rc("flags", A_FLG, 8'h08);
            rc("buffer", A_BUF, 8'h96 + 8'(i));
            rc("status read", A_STA, {1'b0, ~m[0], 6'h00});
            wr(A_FLG, 8'h00);
        end
        wr(A_STA, 8'h40);
        wr(A_CTL, 8'h24);
        sx(8'hff, 3, 1'b0);
        rc("status abort", A_STA, 8'h40);
        sx(8'h69, 8, 1'b0);
        rc("buffer", A_BUF, 8'h69);
        sx(8'hff, 5, 1'b1);
        wr(A_CTL, 8'h04);
        wr(A_CTL, 8'h24);
        sx(8'h5a, 8, 1'b0);
        rc("buffer", A_BUF, 8'h5a);
        wr(A_DIR, 8'h0f);
        fork
            sx(8'h3c, 8, 1'b0);
            begin
                repeat (40) @(posedge pclk);
                chk("sdo drive", {7'h00, pin_out.sdo_oe}, 8'h00);
            end
        join
        rc("buffer", A_BUF, 8'h3c);
        wr(A_DIR, 8'h0e);
        wr(A_FLG, 8'h00);
        wr(A_IE, 8'h08);
        wr(A_PWR, 8'h01);
        sx(8'he1, 8, 1'b0);
        chk("wake", {7'h00, wake_req}, 8'h01);
        wr(A_PWR, 8'h00);
        rc("buffer", A_BUF, 8'he1);
        wr(A_IE, 8'h00);
        wr(A_DIR, 8'h0c);
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            wr(A_FLG, 8'h00);
            wr(A_CTL, {3'b001, m[0], 2'b00, m});
            repeat (2) @(posedge pclk);
            chk("sck idle", {7'h00, pin_out.sck_o}, {7'h00, m[0]});
            t0 = tg;
            wr(A_BUF, 8'h81);
            wr(A_PWR, 8'h01);
            repeat (4) @(posedge pclk);
            t1 = tg;
            repeat (60) @(posedge pclk);
            chk("sleep edges", 8'(tg - t1), 8'h00);
            wr(A_PWR, 8'h00);
            q = 8'h00;
            for (int k = 0; k < 400 && q[0] !== 1'b1; k++) begin
                apb(1'b0, A_STA, 8'h00, q, e);
            end
            // full is set before the last toggle; the slow rate needs 32
            repeat (80) @(posedge pclk);
            chk("sck edges", 8'(tg - t0), 8'h10);
            rc("flags", A_FLG, 8'h08);
            apb(1'b0, A_BUF, 8'h00, q, e);
        end
        wr(A_STA, 8'h00);
        wr(A_CTL, 8'h2b);
        spi_master_model_inst.i2c_cond(1'b1);
        rc("start", A_STA, 8'h08);
        rc("flags", A_FLG, 8'h08);
        spi_master_model_inst.i2c_cond(1'b0);
        rc("stop", A_STA, 8'h10);
        wr(A_FLG, 8'h00);
        wr(A_CTL, 8'h28);
        sx(8'h55, 8, 1'b0);
        rc("reserved flags", A_FLG, 8'h00);
        wr(A_CTL, 8'h24);
        sx(8'h55, 4, 1'b1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rst_chk();
        end_sim();
    end
    initial begin
        repeat (50000) @(posedge pclk);
        fail_count++;
        end_sim();
    end
endmodule
bind sync_serial_port ssp_checker ssp_checker_inst (.pclk(pclk),
    .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .pin_in(pin_in), .pin_out(pin_out), .tmr_tick(tmr_tick),
    .wake_req(wake_req));
